//--- verilog/rcdpll_pkg.sv
package rcdpll_pkg;
  // register map
  localparam logic [7:0] ADDR_PHASE_ERROR = 8'h38;
  localparam logic [7:0] ADDR_FILL_OFFSET = 8'hCD;
  localparam logic [7:0] ADDR_FRAC_SCALE = 8'hD5;
  localparam logic [7:0] ADDR_INT_SCALE = 8'hD7;
  localparam logic [7:0] ADDR_LOOP_GAIN = 8'hD8;
  localparam logic [7:0] ADDR_CONTROL_ONE = 8'hE5;
  localparam logic [7:0] ADDR_CONTROL_FIVE = 8'hE9;
  localparam logic [7:0] ADDR_RX_RESET = 8'hF1;
  localparam logic [7:0] ADDR_CONTROL_SEVEN = 8'hF4;
  // reset values
  localparam logic [7:0] RST_FILL_OFFSET = 8'h40;
  localparam logic [7:0] RST_FRAC_SCALE = 8'h00;
  localparam logic [7:0] RST_INT_SCALE = 8'h06;
  localparam logic [7:0] RST_LOOP_GAIN = 8'h34;
  localparam logic [7:0] RST_CONTROL_ONE = 8'h08;
  localparam logic [7:0] RST_CONTROL_FIVE = 8'h01;
  localparam logic [7:0] RST_CONTROL_SEVEN = 8'h00;
  // field positions
  localparam int MULT_LSB = 0;
  localparam int MULT_MSB = 1;
  localparam int BYPASS_BIT = 2;
  localparam int DIV_LSB = 3;
  localparam int DIV_MSB = 7;
  localparam int LOOP_OPEN_BIT = 0;
  localparam int INIT_MODE_BIT = 0;
  localparam int GAIN_PROP_LSB = 0;
  localparam int GAIN_PROP_MSB = 3;
  localparam int GAIN_INT_LSB = 4;
  localparam int GAIN_INT_MSB = 7;
  // sizes and timing
  localparam int FIFO_DEPTH = 185;
  localparam int PHASE_LIMIT = 511;
  localparam int PCM_FRAME_BITS = 9264;
  localparam logic [17:0] NCO_STEP = 18'h00100;
  localparam logic [17:0] NCO_MIN_PERIOD = 18'h00200;
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_FILL = 3'b010,
    ST_RUN = 3'b100
  } rcdpll_state_type;
endpackage : rcdpll_pkg

//--- verilog/rcdpll_divider.sv
`timescale 1ns/10ps
module rcdpll_divider #(
  parameter int WIDTH = 5
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] div_i,
  output logic tick_o
);
  logic [WIDTH-1:0] cnt_ff;
  logic last;

  // a divide value of zero behaves as one
  assign last = (div_i == '0) || (cnt_ff >= div_i - 1'b1);
  assign tick_o = last;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_ff <= '0;
    end else if (last) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
endmodule : rcdpll_divider

//--- verilog/rcdpll_skid.sv
`timescale 1ns/10ps
module rcdpll_skid #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] mem_ff [0:1];
  logic wptr_ff;
  logic rptr_ff;
  logic [1:0] count_ff;
  logic push;
  logic pop;

  assign in_ready_o = (count_ff != 2'h2);
  assign out_valid_o = (count_ff != 2'h0);
  assign out_data_o = mem_ff[rptr_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i || flush_i) begin
      wptr_ff <= 1'b0;
      rptr_ff <= 1'b0;
      count_ff <= 2'h0;
    end else begin
      if (push) begin
        wptr_ff <= ~wptr_ff;
      end
      if (pop) begin
        rptr_ff <= ~rptr_ff;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 2'h1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 2'h1;
      end
    end
  end
endmodule : rcdpll_skid

//--- verilog/rcdpll_core.sv
`timescale 1ns/10ps
// Function
// [RQ1] pcm sync lags line frame by offset
// [RQ2] line writes fifo during offset before reads
// [RQ3] software offset covers overhead, delay, variance
// [RQ4] software offset stays below depth limits
// [RQ5] offset applied only at receiver reset
// [RQ6] receive clock synthesized from fast clock
// [RQ7] fast clock source from multiplier, bypass
// [RQ8] loop mode bit picks open/closed
// [RQ9] closed loop nominal from integer, fraction
// [RQ10] closed loop adjusts phase from filter
// [RQ11] error measured pcm sync to line frame
// [RQ12] error counted in divided count clock
// [RQ13] error register updates at line frame
// [RQ14] error beyond 511 reinitializes detector
// [RQ15] type two filter, gain sets bandwidth
// [RQ16] open loop ignores detector error
// [RQ17] reset register is write-only strobe
module rcdpll_core
  #(
  parameter int FRAME_BITS = rcdpll_pkg::PCM_FRAME_BITS,
  parameter int DEPTH = rcdpll_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] mpu_addr_i,
  input wire logic mpu_wr_i,
  input wire logic mpu_rd_i,
  input wire logic [7:0] mpu_wdata_i,
  output logic [7:0] mpu_rdata_o,
  input wire logic line_frame_i,
  input wire logic line_valid_i,
  input wire logic line_bit_i,
  output logic line_ready_o,
  output logic pcm_clk_o,
  output logic pcm_sync_o,
  output logic pcm_valid_o,
  input wire logic pcm_ready_i,
  output logic pcm_data_o,
  output logic [1:0] analog_multiplier_setting_o,
  output logic analog_bypass_setting_o
);
  import rcdpll_pkg::*;

  // pin synchronisers
  logic frame_s1_ff, frame_s2_ff, frame_d_ff;
  logic valid_s1_ff, valid_s2_ff;
  logic bit_s1_ff, bit_s2_ff;
  logic line_frame;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      frame_s1_ff <= 1'b0;
      frame_s2_ff <= 1'b0;
      frame_d_ff <= 1'b0;
      valid_s1_ff <= 1'b0;
      valid_s2_ff <= 1'b0;
      bit_s1_ff <= 1'b0;
      bit_s2_ff <= 1'b0;
    end else begin
      frame_s1_ff <= line_frame_i;
      frame_s2_ff <= frame_s1_ff;
      frame_d_ff <= frame_s2_ff;
      valid_s1_ff <= line_valid_i;
      valid_s2_ff <= valid_s1_ff;
      bit_s1_ff <= line_bit_i;
      bit_s2_ff <= bit_s1_ff;
    end
  end

  assign line_frame = frame_s2_ff && !frame_d_ff;

  // register file
  logic [7:0] fill_offset_ff;
  logic [7:0] frac_scale_ff;
  logic [7:0] int_scale_ff;
  logic [7:0] loop_gain_ff;
  logic [7:0] control_one_ff;
  logic [7:0] control_five_ff;
  logic [7:0] control_seven_ff;
  logic [7:0] phase_error_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic rx_reset_cmd;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      fill_offset_ff <= RST_FILL_OFFSET;
      frac_scale_ff <= RST_FRAC_SCALE;
      int_scale_ff <= RST_INT_SCALE;
      loop_gain_ff <= RST_LOOP_GAIN;
      control_one_ff <= RST_CONTROL_ONE;
      control_five_ff <= RST_CONTROL_FIVE;
      control_seven_ff <= RST_CONTROL_SEVEN;
    end else if (mpu_wr_i) begin
      if (mpu_addr_i == ADDR_FILL_OFFSET) begin
        fill_offset_ff <= mpu_wdata_i;
      end else if (mpu_addr_i == ADDR_FRAC_SCALE) begin
        frac_scale_ff <= mpu_wdata_i;
      end else if (mpu_addr_i == ADDR_INT_SCALE) begin
        int_scale_ff <= mpu_wdata_i;
      end else if (mpu_addr_i == ADDR_LOOP_GAIN) begin
        loop_gain_ff <= mpu_wdata_i;
      end else if (mpu_addr_i == ADDR_CONTROL_ONE) begin
        control_one_ff <= mpu_wdata_i;
      end else if (mpu_addr_i == ADDR_CONTROL_FIVE) begin
        control_five_ff <= mpu_wdata_i;
      end else if (mpu_addr_i == ADDR_CONTROL_SEVEN) begin
        control_seven_ff <= mpu_wdata_i;
      end
    end
  end

  assign rx_reset_cmd = mpu_wr_i && (mpu_addr_i == ADDR_RX_RESET); // RQ17

  always_comb begin
    nxt_rdata = 8'h00;
    if (mpu_addr_i == ADDR_PHASE_ERROR) begin
      nxt_rdata = phase_error_ff;
    end else if (mpu_addr_i == ADDR_FILL_OFFSET) begin
      nxt_rdata = fill_offset_ff;
    end else if (mpu_addr_i == ADDR_FRAC_SCALE) begin
      nxt_rdata = frac_scale_ff;
    end else if (mpu_addr_i == ADDR_INT_SCALE) begin
      nxt_rdata = int_scale_ff;
    end else if (mpu_addr_i == ADDR_LOOP_GAIN) begin
      nxt_rdata = loop_gain_ff;
    end else if (mpu_addr_i == ADDR_CONTROL_ONE) begin
      nxt_rdata = control_one_ff;
    end else if (mpu_addr_i == ADDR_CONTROL_FIVE) begin
      nxt_rdata = control_five_ff;
    end else if (mpu_addr_i == ADDR_CONTROL_SEVEN) begin
      nxt_rdata = control_seven_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_ff <= 8'h00;
    end else if (mpu_rd_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign mpu_rdata_o = rdata_ff;
  // clock source selection drives the analog multiplier pins
  assign analog_multiplier_setting_o = control_one_ff[MULT_MSB:MULT_LSB]; // RQ7
  assign analog_bypass_setting_o = control_one_ff[BYPASS_BIT]; // RQ7

  logic loop_open;
  assign loop_open = control_five_ff[LOOP_OPEN_BIT]; // RQ8

  // numeric oscillator: period in 1/256 fast-clock cycles
  logic signed [11:0] adjust_ff;
  logic [17:0] nominal;
  logic [17:0] eff_period;
  logic [17:0] nco_sum;
  logic [17:0] acc_ff;
  logic [17:0] acc_next;
  logic [17:0] acc_rem;
  logic nco_tick;
  logic pcm_clk_ff;
  logic bit_tick;

  always_comb begin
    nominal = {2'b00, int_scale_ff, frac_scale_ff}; // RQ9 RQ6
    if (loop_open) begin
      nco_sum = nominal; // RQ16
    end else begin
      nco_sum = nominal + {{6{adjust_ff[11]}}, adjust_ff}; // RQ10
    end
    eff_period = nco_sum;
    if (nco_sum[17] || nco_sum < NCO_MIN_PERIOD) begin
      eff_period = NCO_MIN_PERIOD;
    end
  end

  assign acc_next = acc_ff + NCO_STEP;
  assign acc_rem = acc_next - eff_period;
  assign nco_tick = (acc_next >= eff_period);
  assign bit_tick = nco_tick && pcm_clk_ff;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      acc_ff <= 18'h00000;
      pcm_clk_ff <= 1'b0;
    end else if (nco_tick) begin
      // a period cut mid-count must not give back-to-back ticks
      acc_ff <= (acc_rem < NCO_STEP) ? acc_rem : 18'h00000;
      pcm_clk_ff <= ~pcm_clk_ff;
    end else begin
      acc_ff <= acc_next;
    end
  end

  assign pcm_clk_o = pcm_clk_ff;

  // frame alignment
  rcdpll_state_type state_ff;
  logic [7:0] offset_lat_ff;
  logic [7:0] offset_cnt_ff;
  logic [13:0] bit_cnt_ff;
  logic sync_evt;
  logic sync_ff;
  logic restart;
  logic pd_restart;
  logic fill_done;
  logic frame_wrap;

  assign restart = rx_reset_cmd || pd_restart;
  assign fill_done = bit_tick && (offset_cnt_ff + 8'h01 >= offset_lat_ff);
  assign frame_wrap = bit_tick &&
    (bit_cnt_ff == 14'(FRAME_BITS - 1));

  always_comb begin
    sync_evt = 1'b0;
    case (state_ff)
      ST_WAIT: sync_evt = line_frame && (offset_lat_ff == 8'h00);
      ST_FILL: sync_evt = fill_done; // RQ1
      ST_RUN: sync_evt = frame_wrap;
      default: sync_evt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      offset_lat_ff <= RST_FILL_OFFSET;
    end else if (rx_reset_cmd) begin
      offset_lat_ff <= fill_offset_ff; // RQ5
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i || restart) begin
      state_ff <= ST_WAIT;
      offset_cnt_ff <= 8'h00;
      bit_cnt_ff <= 14'h0000;
    end else begin
      case (state_ff)
        ST_WAIT: begin
          offset_cnt_ff <= 8'h00;
          bit_cnt_ff <= 14'h0000;
          if (line_frame) begin
            state_ff <= (offset_lat_ff == 8'h00) ? ST_RUN : ST_FILL;
          end
        end
        ST_FILL: begin
          if (fill_done) begin
            state_ff <= ST_RUN; // RQ2
          end else if (bit_tick) begin
            offset_cnt_ff <= offset_cnt_ff + 8'h01;
          end
        end
        ST_RUN: begin
          if (frame_wrap) begin
            bit_cnt_ff <= 14'h0000;
          end else if (bit_tick) begin
            bit_cnt_ff <= bit_cnt_ff + 14'h0001;
          end
        end
        default: state_ff <= ST_WAIT;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sync_ff <= 1'b0;
    end else begin
      sync_ff <= sync_evt && !restart; // RQ5
    end
  end

  assign pcm_sync_o = sync_ff;

  // receive elastic fifo, one bit per entry
  logic mem_ff [0:DEPTH-1];
  logic [7:0] wptr_ff;
  logic [7:0] rptr_ff;
  logic [7:0] level_ff;
  logic push;
  logic pop;
  logic skid_ready;
  logic fifo_full;

  assign fifo_full = (level_ff == 8'(DEPTH));
  assign line_ready_o = (state_ff != ST_WAIT) && !fifo_full;
  assign push = valid_s2_ff && line_ready_o; // RQ2
  assign pop = (state_ff == ST_RUN) && bit_tick && (level_ff != 8'h00) &&
    skid_ready;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wptr_ff] <= bit_s2_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i || restart || state_ff == ST_WAIT) begin
      wptr_ff <= 8'h00;
      rptr_ff <= 8'h00;
      level_ff <= 8'h00;
    end else begin
      if (push) begin
        wptr_ff <= (wptr_ff == 8'(DEPTH - 1)) ? 8'h00 : wptr_ff + 8'h01;
      end
      if (pop) begin
        rptr_ff <= (rptr_ff == 8'(DEPTH - 1)) ? 8'h00 : rptr_ff + 8'h01;
      end
      if (push && !pop) begin
        level_ff <= level_ff + 8'h01;
      end else if (pop && !push) begin
        level_ff <= level_ff - 8'h01;
      end
    end
  end

  // output buffer absorbs a stall by the pcm receiver
  rcdpll_skid #(
    .WIDTH(1)
  ) u_skid (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .flush_i(restart),
    .in_valid_i(pop),
    .in_ready_o(skid_ready),
    .in_data_i(mem_ff[rptr_ff]),
    .out_valid_o(pcm_valid_o),
    .out_ready_i(pcm_ready_i),
    .out_data_o(pcm_data_o)
  );

  // phase detector on the divided count clock
  logic count_tick;
  logic [17:0] pd_cnt_ff;
  logic [17:0] pd_ref_ff;
  logic pd_ref_valid_ff;
  logic signed [18:0] pd_err;
  logic pd_over;
  logic pd_update;

  rcdpll_divider #(
    .WIDTH(DIV_MSB - DIV_LSB + 1)
  ) u_count_div (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .div_i(control_one_ff[DIV_MSB:DIV_LSB]),
    .tick_o(count_tick)
  ); // RQ12

  always_ff @(posedge clk_i) begin
    if (!resetn_i || sync_evt) begin
      pd_cnt_ff <= 18'h00000; // RQ11
    end else if (count_tick && pd_cnt_ff != 18'h3FFFF) begin
      pd_cnt_ff <= pd_cnt_ff + 18'h00001; // RQ12
    end
  end

  assign pd_update = line_frame && (state_ff == ST_RUN);
  assign pd_err = $signed({1'b0, pd_cnt_ff}) - $signed({1'b0, pd_ref_ff});
  assign pd_over = pd_ref_valid_ff &&
    (pd_err > 19'sd511 || pd_err < -19'sd511); // RQ14
  assign pd_restart = pd_update && pd_over &&
    control_seven_ff[INIT_MODE_BIT]; // RQ14

  always_ff @(posedge clk_i) begin
    if (!resetn_i || rx_reset_cmd || state_ff != ST_RUN) begin
      pd_ref_ff <= 18'h00000;
      pd_ref_valid_ff <= 1'b0;
    end else if (pd_update && (!pd_ref_valid_ff || pd_over)) begin
      pd_ref_ff <= pd_cnt_ff; // RQ14
      pd_ref_valid_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      phase_error_ff <= 8'h00;
    end else if (pd_update) begin
      if (!pd_ref_valid_ff || pd_over) begin
        phase_error_ff <= 8'h00;
      end else if (pd_err > 19'sd127) begin
        phase_error_ff <= 8'h7F; // RQ13
      end else if (pd_err < -19'sd128) begin
        phase_error_ff <= 8'h80;
      end else begin
        phase_error_ff <= pd_err[7:0]; // RQ13
      end
    end
  end

  // type two loop filter: proportional plus integral path
  logic signed [18:0] integ_ff;
  logic signed [18:0] prop;
  logic signed [18:0] integ_step;
  logic signed [19:0] filt_sum;
  logic [4:0] int_shift;
  logic err_ok;

  assign err_ok = pd_update && pd_ref_valid_ff && !pd_over;
  assign int_shift = {1'b0, loop_gain_ff[GAIN_INT_MSB:GAIN_INT_LSB]} +
    {1'b0, loop_gain_ff[GAIN_PROP_MSB:GAIN_PROP_LSB]};
  assign prop = pd_err >>> loop_gain_ff[GAIN_PROP_MSB:GAIN_PROP_LSB];
  assign integ_step = pd_err >>> int_shift; // RQ15
  assign filt_sum = {prop[18], prop} + {integ_ff[18], integ_ff} +
    {integ_step[18], integ_step};

  always_ff @(posedge clk_i) begin
    if (!resetn_i || loop_open || restart) begin
      integ_ff <= 19'sd0; // RQ16
      adjust_ff <= 12'sd0;
    end else if (err_ok) begin
      integ_ff <= integ_ff + integ_step; // RQ15
      if (filt_sum > 20'sd2047) begin
        adjust_ff <= 12'sd2047;
      end else if (filt_sum < -20'sd2048) begin
        adjust_ff <= -12'sd2048;
      end else begin
        adjust_ff <= filt_sum[11:0]; // RQ10
      end
    end
  end
endmodule : rcdpll_core

//--- verification/rcdpll_pcm_sink.sv
`timescale 1ns/10ps
// downstream pcm framer: takes bits on valid and ready, stalls on demand
module rcdpll_pcm_sink (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic stall_i,
  input wire logic pcm_valid_i,
  input wire logic pcm_data_i,
  output logic pcm_ready_o,
  output logic [15:0] first_o,
  output logic [15:0] count_o
);
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pcm_ready_o <= 1'b0;
      first_o <= 16'h0000;
      count_o <= 16'h0000;
    end else begin
      pcm_ready_o <= !stall_i;
      if (pcm_valid_i && pcm_ready_o) begin
        count_o <= count_o + 16'h0001;
        if (count_o < 16'h0010) begin
          first_o <= {first_o[14:0], pcm_data_i};
        end
      end
    end
  end
endmodule : rcdpll_pcm_sink

//--- verification/rcdpll_chk.sv
`timescale 1ns/10ps
module rcdpll_chk
  import rcdpll_pkg::*;
#(
  parameter int FRAME_BITS = 64,
  parameter int DEPTH = 185
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] mpu_addr_i,
  input wire logic mpu_wr_i,
  input wire logic mpu_rd_i,
  input wire logic [7:0] mpu_wdata_i,
  input wire logic [7:0] mpu_rdata_o,
  input wire logic line_frame_i,
  input wire logic line_valid_i,
  input wire logic line_bit_i,
  input wire logic line_ready_o,
  input wire logic pcm_clk_o,
  input wire logic pcm_sync_o,
  input wire logic pcm_valid_o,
  input wire logic pcm_ready_i,
  input wire logic pcm_data_o,
  input wire logic [1:0] analog_multiplier_setting_o,
  input wire logic analog_bypass_setting_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence seq_strobe;
    mpu_wr_i && mpu_addr_i == ADDR_RX_RESET;
  endsequence
  sequence seq_ctl_one;
    mpu_wr_i && mpu_addr_i == ADDR_CONTROL_ONE;
  endsequence
  AST_STROBE_READ_ZERO: assert property (
    mpu_rd_i && mpu_addr_i == ADDR_RX_RESET |=> mpu_rdata_o == 8'h00)
    else $error("receiver reset register read back nonzero");
  AST_STROBE_WAIT: assert property (
    seq_strobe |=> !line_ready_o)
    else $error("fifo accepting right after receiver reset");
  AST_STROBE_NO_SYNC: assert property (
    seq_strobe |=> !pcm_sync_o [*8])
    else $error("pcm sync too soon after receiver reset");
  AST_MULT_FOLLOWS: assert property (
    seq_ctl_one |=> analog_multiplier_setting_o ==
      $past(mpu_wdata_i[MULT_MSB:MULT_LSB]))
    else $error("multiplier setting does not follow write");
  AST_BYPASS_FOLLOWS: assert property (
    seq_ctl_one |=> analog_bypass_setting_o == $past(mpu_wdata_i[BYPASS_BIT]))
    else $error("bypass setting does not follow write");
  AST_SYNC_PULSE: assert property (
    $rose(pcm_sync_o) |=> !pcm_sync_o)
    else $error("pcm sync longer than one cycle");
  AST_OUT_HELD: assert property (
    pcm_valid_o && !pcm_ready_i |=> pcm_valid_o && $stable(pcm_data_o))
    else $error("pcm output dropped or changed while stalled");
  AST_CLK_HALF_MIN: assert property (
    $changed(pcm_clk_o) |=> $stable(pcm_clk_o))
    else $error("receive clock half period below two cycles");
endmodule : rcdpll_chk

//--- verification/rcdpll_core_bench.sv
`timescale 1ns/10ps
module rcdpll_core_bench;
  import rcdpll_pkg::*;
  localparam int FRAMES = 64;
  // clk cycles per pcm bit at reset scale: 0x0600/256 per tick, two ticks
  localparam int BITP = 12;
  localparam logic [7:0] RW_A [7] = '{ADDR_FILL_OFFSET, ADDR_FRAC_SCALE,
    ADDR_INT_SCALE, ADDR_LOOP_GAIN, ADDR_CONTROL_ONE, ADDR_CONTROL_FIVE,
    ADDR_CONTROL_SEVEN};
  localparam logic [7:0] RW_R [7] = '{RST_FILL_OFFSET, RST_FRAC_SCALE,
    RST_INT_SCALE, RST_LOOP_GAIN, RST_CONTROL_ONE, RST_CONTROL_FIVE,
    RST_CONTROL_SEVEN};
  localparam logic [7:0] RO_A [3] = '{ADDR_PHASE_ERROR, ADDR_RX_RESET, 8'h00};
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] mpu_addr_i = 8'h00;
  logic mpu_wr_i = 1'b0;
  logic mpu_rd_i = 1'b0;
  logic [7:0] mpu_wdata_i = 8'h00;
  logic line_frame_i = 1'b0;
  logic line_valid_i = 1'b0;
  logic line_bit_i = 1'b0;
  logic stall = 1'b0;
  logic frame_en = 1'b0;
  logic [7:0] mpu_rdata_o;
  logic line_ready_o, pcm_clk_o, pcm_sync_o, pcm_valid_o, pcm_ready_i;
  logic pcm_data_o, analog_bypass_setting_o, early;
  logic [1:0] analog_multiplier_setting_o;
  logic [15:0] first16, got_n;
  logic [15:0] sent16 = 16'h0000;
  logic [7:0] rv, inv;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int bits_left = 0;
  int bph = 0;
  int fcnt = 0;
  int nsent = 0;
  int n;
  always #25 clk_i = ~clk_i;
  rcdpll_core #(.FRAME_BITS(FRAMES), .DEPTH(FIFO_DEPTH)) dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .mpu_addr_i(mpu_addr_i),
    .mpu_wr_i(mpu_wr_i), .mpu_rd_i(mpu_rd_i), .mpu_wdata_i(mpu_wdata_i),
    .mpu_rdata_o(mpu_rdata_o), .line_frame_i(line_frame_i),
    .line_valid_i(line_valid_i), .line_bit_i(line_bit_i),
    .line_ready_o(line_ready_o), .pcm_clk_o(pcm_clk_o),
    .pcm_sync_o(pcm_sync_o), .pcm_valid_o(pcm_valid_o),
    .pcm_ready_i(pcm_ready_i), .pcm_data_o(pcm_data_o),
    .analog_multiplier_setting_o(analog_multiplier_setting_o),
    .analog_bypass_setting_o(analog_bypass_setting_o));
  rcdpll_pcm_sink sink_u (.clk_i(clk_i), .resetn_i(resetn_i),
    .stall_i(stall), .pcm_valid_i(pcm_valid_o), .pcm_data_i(pcm_data_o),
    .pcm_ready_o(pcm_ready_i), .first_o(first16), .count_o(got_n));
  // line bits every third cycle; data line wanders between bits
  always @(negedge clk_i) begin
    if (bits_left > 0) bph = (bph + 1) % 3;
    line_valid_i = (bits_left > 0) && (bph == 0);
    line_bit_i = line_valid_i ? (nsent[0] ^ nsent[2]) : ~line_bit_i;
    if (line_valid_i) begin
      if (nsent < 16) sent16 = {sent16[14:0], line_bit_i};
      nsent++;
      bits_left--;
    end
  end
  // free-running line frames, period unrelated to the pcm frame
  always @(negedge clk_i) begin
    if (frame_en) begin
      fcnt = (fcnt + 1) % 700;
      line_frame_i = fcnt < 3;
    end
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task check_eq(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_eq
  task check_range(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : check_range
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    mpu_addr_i = a;
    mpu_wdata_i = d;
    mpu_wr_i = 1'b1;
    @(negedge clk_i);
    mpu_wr_i = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    mpu_addr_i = a;
    mpu_rd_i = 1'b1;
    @(negedge clk_i);
    mpu_rd_i = 1'b0;
    @(negedge clk_i);
    d = mpu_rdata_o;
  endtask : rd
  task pulse_frame();
    @(negedge clk_i);
    line_frame_i = 1'b1;
    repeat (3) @(negedge clk_i);
    line_frame_i = 1'b0;
  endtask : pulse_frame
  // cycles to the next pcm sync; flags output traffic seen before it
  task wait_sync(output int cnt, output logic seen);
    cnt = 0;
    seen = 1'b0;
    do begin
      @(negedge clk_i);
      cnt++;
      seen = seen | (pcm_valid_o & ~pcm_sync_o);
    end while (pcm_sync_o !== 1'b1 && cnt < 4000);
  endtask : wait_sync
  initial begin
    repeat (2) @(negedge clk_i);
    resetn_i = 1'b1;
    for (int i = 0; i < 7; i++) begin
      inv = ~RW_R[i];
      rd(RW_A[i], rv);
      check_eq(rv, RW_R[i]);
      wr(RW_A[i], inv);
      if (i == 4) check_eq({analog_bypass_setting_o,
        analog_multiplier_setting_o}, inv[2:0]);
      rd(RW_A[i], rv);
      check_eq(rv, inv);
      wr(RW_A[i], RW_R[i]);
    end
    for (int i = 0; i < 3; i++) begin
      wr(RO_A[i], 8'hFF);
      rd(RO_A[i], rv);
      check_eq(rv, 8'h00);
    end
    $display("test registers done");
    wr(ADDR_FILL_OFFSET, 8'h40);
    wr(ADDR_RX_RESET, 8'h01);
    pulse_frame();
    bits_left = 195;
    wait_sync(n, early);
    // sync lands inside the last of the offset bit periods
    check_range(n + 3, 63 * BITP + 2, 64 * BITP + 6);
    check_eq(early, 1'b0);
    stall = 1'b1;
    frame_en = 1'b1;
    repeat (100) @(negedge clk_i);
    stall = 1'b0;
    wait_sync(n, early);
    check_range(n + 100, FRAMES * BITP - 2, FRAMES * BITP + 2);
    for (int k = 0; k < 3000 && got_n !== 16'd185; k++) @(negedge clk_i);
    repeat (50) @(negedge clk_i);
    check_eq(got_n, 16'd185);
    check_eq(first16, sent16);
    $display("test fill offset done");
    wr(ADDR_FILL_OFFSET, 8'h10);
    wait_sync(n, early);
    wait_sync(n, early);
    check_range(n, FRAMES * BITP - 1, FRAMES * BITP + 1);
    // strobe well clear of a line frame, so the next frame starts the fill
    @(posedge line_frame_i);
    repeat (10) @(negedge clk_i);
    wr(ADDR_RX_RESET, 8'h01);
    @(posedge line_frame_i);
    wait_sync(n, early);
    check_range(n, 15 * BITP + 2, 16 * BITP + 6);
    $display("test offset latch done");
    wr(ADDR_CONTROL_FIVE, 8'h00);
    repeat (3) wait_sync(n, early);
    rd(ADDR_PHASE_ERROR, rv);
    check_eq(rv != 8'h00, 1'b1);
    $display("test closed loop done");
    tally_and_finish();
  end
endmodule : rcdpll_core_bench
bind rcdpll_core rcdpll_chk #(.FRAME_BITS(FRAME_BITS), .DEPTH(DEPTH)) chk_u (
  .clk_i(clk_i), .resetn_i(resetn_i), .mpu_addr_i(mpu_addr_i),
  .mpu_wr_i(mpu_wr_i), .mpu_rd_i(mpu_rd_i), .mpu_wdata_i(mpu_wdata_i),
  .mpu_rdata_o(mpu_rdata_o), .line_frame_i(line_frame_i),
  .line_valid_i(line_valid_i), .line_bit_i(line_bit_i),
  .line_ready_o(line_ready_o), .pcm_clk_o(pcm_clk_o),
  .pcm_sync_o(pcm_sync_o), .pcm_valid_o(pcm_valid_o),
  .pcm_ready_i(pcm_ready_i), .pcm_data_o(pcm_data_o),
  .analog_multiplier_setting_o(analog_multiplier_setting_o),
  .analog_bypass_setting_o(analog_bypass_setting_o));
